// ### rtl/hc_cfg_pkg.sv
// Constants and types of the command register block
package hc_cfg_pkg;
   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
   localparam logic [7:0] OFS_SUBSYS     = 8'h2C;
   localparam logic [7:0] OFS_TIMING     = 8'h3C;
   localparam logic [7:0] OFS_EXT_FIRST  = 8'hE0;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CMD_IO         = 0;
   localparam int CMD_MEM        = 1;
   localparam int CMD_BM         = 2;
   localparam int CMD_MWI        = 4;
   localparam int CMD_PER        = 6;
   localparam int CMD_SERR       = 8;
   localparam int STS_SSE        = 30;
   localparam int STS_DPE        = 31;
   localparam int EXT_FIRST_LEGACY = 0;
   localparam int EXT_FIRST_UNLOCK = 1;
   localparam logic [15:0] CMD_RW_MASK = 16'h0157;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] CMD_RESET   = 16'h0000;
   localparam logic [7:0]  MIN_GNT_DEF = 8'h01;
   localparam logic [7:0]  MAX_LAT_DEF = 8'h2A;
   // Time for the strap pin to pass the synchroniser
   localparam logic [1:0]  STRAP_WAIT  = 2'h2;
   // ROM word selectors
   localparam logic [1:0]  ROM_SEL_SSVID  = 2'h0;
   localparam logic [1:0]  ROM_SEL_SSID   = 2'h1;
   localparam logic [1:0]  ROM_SEL_TIMING = 2'h2;
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_STRAP, ST_LOAD, ST_READY} load_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic        wr;
      logic [1:0]  sel;
      logic [15:0] data;
      logic        done;
   } rom_load_t;

   typedef struct packed {
      logic        ack;
      logic        retry;
      logic [31:0] rdata;
   } cfg_rsp_t;
endpackage

// ### rtl/pci_command_register_block.sv
// Command register, unlock-writable registers and ROM preload
// Behaviour
// - Bit 0 read/write, resets 0; gates response to I/O accesses.
// - I/O enable cannot become 1 while legacy pin low or legacy mode 0.
// - Bit 1 read/write, resets 0; gates response to memory accesses.
// - Bit 2 read/write, resets 0; no bus master cycle unless set.
// - Bits 3, 5 and 7 read only, return 0.
// - Bit 9 and bits 15 to 10 read only, return 0.
// - Bit 4 read/write, resets 0; invalidate-write command only while set.
// - Bit 6 read/write, resets 0; parity error pin only while set.
// - Detected parity error flag sets on every parity error, always.
// - Bit 8 read/write, resets 0; system error pin only while set.
// - Subsystem and timing registers writable only while unlock bit set.
// - With ROM present, load those registers before accepting accesses.
// - Subsystem registers are 16 bits, fixed defaults without unlock or load.
`timescale 1ns/10ps
module pci_command_register_block
   import hc_cfg_pkg::*;
#(
   parameter logic [15:0] SSVID_DEF = 16'h1234, // Arbitrary value
   parameter logic [15:0] SSID_DEF  = 16'h5678, // Arbitrary value
   parameter logic        LEGACY_MODE_DEF = 1'b0
) (
   input  wire logic      clk_in,
   input  wire logic      sys_rst_in,
   input  wire cfg_req_t  cfg_req_in,
   output cfg_rsp_t       cfg_rsp_out,
   input  wire logic      legacy_sel_in,
   input  wire logic      rom_present_in,
   input  wire rom_load_t rom_load_in,
   input  wire logic      master_req_in,
   input  wire logic      mwi_req_in,
   input  wire logic      parity_err_in,
   input  wire logic      perr_req_in,
   input  wire logic      serr_req_in,
   output logic           io_decode_en_out,
   output logic           mem_decode_en_out,
   output logic           bus_master_en_out,
   output logic           master_req_out,
   output logic           mwi_cmd_out,
   output logic           perr_out,
   output logic           serr_out,
   output logic           cfg_ready_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  leg_sync;
      logic [1:0]  rom_sync;
      load_state_t st;
      logic [1:0]  wait_cnt;
      logic [15:0] cmd;
      logic        dpe;
      logic        sse;
      logic        legacy_mode;
      logic        id_unlock;
      logic [15:0] ssvid;
      logic [15:0] ssid;
      logic [7:0]  min_gnt;
      logic [7:0]  max_lat;
      logic        ack;
      logic [31:0] rdata;
   } state_t;

   localparam state_t STATE_RESET = '{
      leg_sync: 2'h0, rom_sync: 2'h0, st: ST_STRAP, wait_cnt: 2'h0,
      cmd: CMD_RESET, dpe: 1'b0, sse: 1'b0,
      legacy_mode: LEGACY_MODE_DEF, id_unlock: 1'b0,
      ssvid: SSVID_DEF, ssid: SSID_DEF,
      min_gnt: MIN_GNT_DEF, max_lat: MAX_LAT_DEF,
      ack: 1'b0, rdata: 32'h0000_0000};

   state_t      state;
   state_t      next_state;
   logic        legacy_ok;
   logic        acc;
   logic        acc_wr;
   logic [15:0] cmd_wr;

   assign legacy_ok = state.leg_sync[1] & state.legacy_mode;
   assign acc       = cfg_req_in.valid & (state.st == ST_READY);
   assign acc_wr    = acc & cfg_req_in.write;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.leg_sync = {state.leg_sync[0], legacy_sel_in};
      next_state.rom_sync = {state.rom_sync[0], rom_present_in};
      next_state.ack = acc;
      cmd_wr = state.cmd;
      if (cfg_req_in.be[0]) begin
         cmd_wr[7:0] = cfg_req_in.wdata[7:0];
      end
      if (cfg_req_in.be[1]) begin
         cmd_wr[15:8] = cfg_req_in.wdata[15:8];
      end
      cmd_wr = cmd_wr & CMD_RW_MASK;
      cmd_wr[CMD_IO] = cmd_wr[CMD_IO] & legacy_ok;

      case (state.st)
         ST_STRAP: begin
            next_state.wait_cnt = state.wait_cnt + 2'h1;
            if (state.wait_cnt == STRAP_WAIT) begin
               if (state.rom_sync[1]) begin
                  next_state.st = ST_LOAD;
               end else begin
                  next_state.st = ST_READY;
               end
            end
         end
         ST_LOAD: begin
            if (rom_load_in.wr) begin
               case (rom_load_in.sel)
                  ROM_SEL_SSVID: next_state.ssvid = rom_load_in.data;
                  ROM_SEL_SSID:  next_state.ssid  = rom_load_in.data;
                  ROM_SEL_TIMING: begin
                     next_state.min_gnt = rom_load_in.data[7:0];
                     next_state.max_lat = rom_load_in.data[15:8];
                  end
                  default: next_state.ssvid = state.ssvid;
               endcase
            end
            if (rom_load_in.done) begin
               next_state.st = ST_READY;
            end
         end
         ST_READY: begin
            if (acc_wr) begin
               case (cfg_req_in.addr)
                  OFS_CMD_STATUS: begin
                     next_state.cmd = cmd_wr;
                  end
                  OFS_SUBSYS: begin
                     if (state.id_unlock) begin
                        if (cfg_req_in.be[0]) begin
                           next_state.ssvid[7:0] = cfg_req_in.wdata[7:0];
                        end
                        if (cfg_req_in.be[1]) begin
                           next_state.ssvid[15:8] = cfg_req_in.wdata[15:8];
                        end
                        if (cfg_req_in.be[2]) begin
                           next_state.ssid[7:0] = cfg_req_in.wdata[23:16];
                        end
                        if (cfg_req_in.be[3]) begin
                           next_state.ssid[15:8] = cfg_req_in.wdata[31:24];
                        end
                     end
                  end
                  OFS_TIMING: begin
                     if (state.id_unlock) begin
                        if (cfg_req_in.be[2]) begin
                           next_state.min_gnt = cfg_req_in.wdata[23:16];
                        end
                        if (cfg_req_in.be[3]) begin
                           next_state.max_lat = cfg_req_in.wdata[31:24];
                        end
                     end
                  end
                  OFS_EXT_FIRST: begin
                     if (cfg_req_in.be[0]) begin
                        next_state.legacy_mode =
                           cfg_req_in.wdata[EXT_FIRST_LEGACY];
                        next_state.id_unlock =
                           cfg_req_in.wdata[EXT_FIRST_UNLOCK];
                     end
                  end
                  default: next_state.cmd = state.cmd;
               endcase
            end
            if (acc & !cfg_req_in.write) begin
               case (cfg_req_in.addr)
                  OFS_CMD_STATUS: next_state.rdata =
                     {state.dpe, state.sse, 14'h0000, state.cmd};
                  OFS_SUBSYS:     next_state.rdata = {state.ssid, state.ssvid};
                  OFS_TIMING:     next_state.rdata =
                     {state.max_lat, state.min_gnt, 16'h0000};
                  OFS_EXT_FIRST:  next_state.rdata =
                     {30'h0000_0000, state.id_unlock, state.legacy_mode};
                  default:        next_state.rdata = 32'h0000_0000;
               endcase
            end
         end
         default: next_state.st = ST_STRAP;
      endcase

      // Write-one-to-clear status flags; a new event wins over the clear
      if (acc_wr && cfg_req_in.addr == OFS_CMD_STATUS
          && cfg_req_in.be[3]) begin
         if (cfg_req_in.wdata[STS_DPE]) begin
            next_state.dpe = 1'b0;
         end
         if (cfg_req_in.wdata[STS_SSE]) begin
            next_state.sse = 1'b0;
         end
      end
      if (parity_err_in) begin
         next_state.dpe = 1'b1;
      end
      if (serr_out) begin
         next_state.sse = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign io_decode_en_out  = state.cmd[CMD_IO];
   assign mem_decode_en_out = state.cmd[CMD_MEM];
   assign bus_master_en_out = state.cmd[CMD_BM];
   assign master_req_out    = master_req_in & state.cmd[CMD_BM];
   assign mwi_cmd_out = mwi_req_in & state.cmd[CMD_BM]
                        & state.cmd[CMD_MWI];
   assign perr_out    = perr_req_in & state.cmd[CMD_PER];
   assign serr_out    = serr_req_in & state.cmd[CMD_SERR];
   assign cfg_ready_out     = (state.st == ST_READY);
   assign cfg_rsp_out.ack   = state.ack;
   assign cfg_rsp_out.rdata = state.rdata;
   assign cfg_rsp_out.retry = cfg_req_in.valid & (state.st != ST_READY);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_io_set_try;
      acc_wr && cfg_req_in.addr == OFS_CMD_STATUS && cfg_req_in.be[0]
         && cfg_req_in.wdata[CMD_IO];
   endsequence

   a_io_refused: assert property ((s_io_set_try and !legacy_ok)
      |=> !io_decode_en_out) else $error("io enable set while locked");
   a_io_accepted: assert property ((s_io_set_try and legacy_ok)
      |=> io_decode_en_out) else $error("io enable write lost");
   a_ro_zero: assert property ((state.cmd & ~CMD_RW_MASK) == 16'h0000)
      else $error("read only command bit set");
   a_master_gate: assert property (master_req_out |-> state.cmd[CMD_BM])
      else $error("master without enable");
   a_mwi_gate: assert property (mwi_cmd_out |-> state.cmd[CMD_MWI])
      else $error("invalidate write without enable");
   a_perr_gate: assert property (perr_out |-> state.cmd[CMD_PER])
      else $error("parity pin without enable");
   a_serr_gate: assert property (serr_out |-> state.cmd[CMD_SERR])
      else $error("system error pin without enable");
   a_dpe_sets: assert property (parity_err_in |=> state.dpe)
      else $error("parity flag not set");
   a_unlock_guard: assert property (acc_wr && !state.id_unlock
      && cfg_req_in.addr == OFS_SUBSYS |=> $stable(state.ssid)
      && $stable(state.ssvid)) else $error("locked id written");
   a_load_blocks: assert property (state.st == ST_LOAD
      && cfg_req_in.valid |-> cfg_rsp_out.retry ##1 !cfg_rsp_out.ack)
      else $error("access during rom load");
   a_no_rom: assert property (state.st == ST_STRAP
      && state.wait_cnt == STRAP_WAIT && !state.rom_sync[1]
      |=> cfg_ready_out) else $error("no ready without rom");
   a_ack_next: assert property (acc |=> cfg_rsp_out.ack)
      else $error("access not answered");
endmodule

// ### bench/rom_loader_model.sv
// Serial ROM preload engine model feeding the block
`timescale 1ns/10ps
module rom_loader_model
   import hc_cfg_pkg::*;
#(
   parameter int DELAY = 8
) (
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic enable_in,
   output rom_load_t rom_load_out
);
   logic [15:0] words [3];
   int          cnt;
   initial begin
      words[0] = 16'hA5C3;
      words[1] = 16'h3C5A;
      words[2] = 16'h4D21;
   end
   always @(posedge clk_in) begin
      rom_load_out.wr <= 1'b0;
      rom_load_out.done <= 1'b0;
      rom_load_out.data <= ~rom_load_out.data;
      if (sys_rst_in) begin
         cnt <= 0;
         rom_load_out.sel <= 2'h0;
         rom_load_out.data <= 16'h0000;
      end else if (enable_in && cnt < DELAY + 4) begin
         cnt <= cnt + 1;
         if (cnt >= DELAY && cnt < DELAY + 3) begin
            rom_load_out.wr <= 1'b1;
            rom_load_out.sel <= 2'(cnt - DELAY);
            rom_load_out.data <= words[cnt - DELAY];
         end
         rom_load_out.done <= (cnt == DELAY + 3);
      end
   end
endmodule

// ### bench/pci_command_register_block_tb.sv
// Self-checking bench of the command register block
`timescale 1ns/10ps
module pci_command_register_block_tb
   import hc_cfg_pkg::*;
;
   localparam logic [15:0] SSV = 16'h1A2B; // Arbitrary value
   localparam logic [15:0] SSI = 16'h3C4D; // Arbitrary value
   logic      clk_in = 1'b0;
   logic      sys_rst_in = 1'b1;
   cfg_req_t  req = '0;
   cfg_rsp_t  rsp;
   rom_load_t rom;
   logic      leg = 1'b0;
   logic      rom_on = 1'b0;
   logic [3:0] rq = 4'h0;
   logic      par = 1'b0;
   logic      io, mem, bm, mo, mwi, pe, se, rdy;
   int        error_cnt = 0;
   int        checks = 0;
   int        n;

   always #10 clk_in = ~clk_in;

   rom_loader_model rom_model (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .enable_in    (rom_on),
      .rom_load_out (rom)
   );

   pci_command_register_block #(.SSVID_DEF(SSV), .SSID_DEF(SSI)) uut (
      .clk_in            (clk_in),
      .sys_rst_in        (sys_rst_in),
      .cfg_req_in        (req),
      .cfg_rsp_out       (rsp),
      .legacy_sel_in     (leg),
      .rom_present_in    (rom_on),
      .rom_load_in       (rom),
      .master_req_in     (rq[3]),
      .mwi_req_in        (rq[2]),
      .parity_err_in     (par),
      .perr_req_in       (rq[1]),
      .serr_req_in       (rq[0]),
      .io_decode_en_out  (io),
      .mem_decode_en_out (mem),
      .bus_master_en_out (bm),
      .master_req_out    (mo),
      .mwi_cmd_out       (mwi),
      .perr_out          (pe),
      .serr_out          (se),
      .cfg_ready_out     (rdy)
   );

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_in);
      req <= '{1'b1, w, a, be, d};
      @(posedge clk_in);
      req.valid <= 1'b0;
      #1;
      check("ack", rsp.ack, 1'b1);
   endtask

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      acc(1'b0, a, 4'hF, 32'h0);
      check(nm, rsp.rdata, exp);
   endtask

   task automatic do_reset();
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      req <= '{1'b1, 1'b0, 8'h04, 4'hF, 32'h0};
      #1;
      check("retry", rsp.retry, 1'b1);
      @(posedge clk_in);
      req.valid <= 1'b0;
      #1;
      check("no_ack", rsp.ack, 1'b0);
      n = 1;
      while (rdy !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask

   initial begin
      #(20 * 5000);
      error_cnt++;
      final_report();
   end

   initial begin
      do_reset();
      check("ready_delay", n <= 5, 1'b1);
      rd("cmd_reset", 8'h04, 32'h0);
      check("enables", {io, mem, bm}, 3'h0);
      acc(1'b1, 8'h04, 4'h3, 32'h0000FFFF);
      rd("cmd_ro", 8'h04, 32'h00000156);
      check("enables", {io, mem, bm}, 3'h3);
      $display("test reset and access kinds done");
      @(posedge clk_in);
      rq <= 4'hF;
      for (int i = 1; i >= 0; i--) begin
         acc(1'b1, 8'h04, 4'h3, i ? 32'h0156 : 32'h0);
         check("gates", {mo, mwi, pe, se}, i ? 4'hF : 4'h0);
      end
      @(posedge clk_in);
      rq <= 4'h0;
      par <= 1'b1;
      @(posedge clk_in);
      par <= 1'b0;
      acc(1'b0, 8'h04, 4'hF, 32'h0);
      check("dpe", rsp.rdata[31], 1'b1);
      acc(1'b1, 8'h04, 4'h8, 32'hC0000000);
      rd("sts_clear", 8'h04, 32'h0);
      $display("test gating and parity done");
      @(posedge clk_in);
      leg <= 1'b1;
      acc(1'b1, 8'hE0, 4'h1, 32'h1);
      repeat (3) @(posedge clk_in);
      acc(1'b1, 8'h04, 4'h3, 32'h1);
      check("io_en", io, 1'b1);
      rd("cmd_io", 8'h04, 32'h1);
      @(posedge clk_in);
      leg <= 1'b0;
      repeat (3) @(posedge clk_in);
      acc(1'b1, 8'h04, 4'h3, 32'h1);
      rd("cmd_io_refused", 8'h04, 32'h0);
      $display("test legacy gate done");
      rd("subsys_def", 8'h2C, {SSI, SSV});
      rd("timing_def", 8'h3C, {MAX_LAT_DEF, MIN_GNT_DEF, 16'h0});
      acc(1'b1, 8'h2C, 4'hF, 32'hFFFF0000);
      acc(1'b1, 8'h3C, 4'hC, 32'h77660000);
      rd("subsys_locked", 8'h2C, {SSI, SSV});
      rd("timing_locked", 8'h3C, {MAX_LAT_DEF, MIN_GNT_DEF, 16'h0});
      acc(1'b1, 8'hE0, 4'h1, 32'h2);
      acc(1'b1, 8'h2C, 4'hF, 32'hBEEFCAFE);
      acc(1'b1, 8'h3C, 4'hC, 32'h77660000);
      rd("subsys_open", 8'h2C, 32'hBEEFCAFE);
      rd("timing_open", 8'h3C, 32'h77660000);
      $display("test unlock done");
      @(posedge clk_in);
      rom_on <= 1'b1;
      do_reset();
      check("rom_wait", n > 10, 1'b1);
      rd("subsys_rom", 8'h2C, 32'h3C5AA5C3);
      rd("timing_rom", 8'h3C, 32'h4D210000);
      $display("test rom preload done");
      final_report();
   end
endmodule
